// ===== fwdirq_regs.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`include "fwdirq_cfg.svh"
module fwdirq_regs (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire fwdirq_pkg::fwdirq_apb_req_type i_apb,
    output fwdirq_pkg::fwdirq_apb_rsp_type o_apb,
    input wire logic [1:0] i_sync_fwd_mode,
    input wire logic i_engine_locked,
    input wire logic i_frame_forwarded,
    input wire logic i_sync_lost,
    input wire logic i_tx_irq,
    input wire logic i_tx_event_read,
    input wire logic [1:0] i_rx_irq,
    input wire logic [1:0] i_rx_event_read,
    input wire logic i_frame_sync,
    input wire logic [1:0] i_line_start,
    input wire logic [1:0] i_frame_start,
    output logic o_irq,
    output logic o_stamp_ready
);
    //--------------------------------------------------
    // register bus
    //--------------------------------------------------
    // data is latched in the setup cycle; read clears only drop the bits that were shown
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    wire setup = i_apb.psel & ~i_apb.penable;
    wire acc = i_apb.psel & i_apb.penable & pready;
    wire [5:0] idx = i_apb.paddr[7:2];
    wire aligned = (i_apb.paddr[1:0] == 2'h0);
    wire hit_fwd = aligned & (idx == `FWDIRQ_I_FWD);
    wire hit_ien = aligned & (idx == `FWDIRQ_I_IEN);
    wire hit_isrc = aligned & (idx == `FWDIRQ_I_ISRC);
    wire hit_cfg = aligned & (idx == `FWDIRQ_I_TSCFG);
    wire hit_ctl = aligned & (idx == `FWDIRQ_I_TSCTL);
    wire hit_lhi = aligned & (idx == `FWDIRQ_I_LHI);
    wire hit_llo = aligned & (idx == `FWDIRQ_I_LLO);
    wire hit_sts = aligned & (idx == `FWDIRQ_I_TSSTS);
    wire hit_t0h = aligned & (idx == `FWDIRQ_I_T0HI);
    wire hit_t0l = aligned & (idx == `FWDIRQ_I_T0LO);
    wire hit_t1h = aligned & (idx == `FWDIRQ_I_T1HI);
    wire hit_t1l = aligned & (idx == `FWDIRQ_I_T1LO);
    wire hit_evs = aligned & (idx == `FWDIRQ_I_EVS);
    wire hit_evm = aligned & (idx == `FWDIRQ_I_EVM);
    wire hit_any = hit_fwd | hit_ien | hit_isrc | hit_cfg | hit_ctl | hit_lhi | hit_llo | hit_sts
        | hit_t0h | hit_t0l | hit_t1h | hit_t1l | hit_evs | hit_evm;
    wire wr = acc & i_apb.pwrite & ~pslverr;
    wire rd = acc & ~i_apb.pwrite;
    wire [7:0] wdat = i_apb.pwdata[7:0];

    //--------------------------------------------------
    // state
    //--------------------------------------------------
    fwdirq_pkg::fwdirq_sync_type sync_state;
    fwdirq_pkg::fwdirq_sync_type next_sync_state;
    logic sync_fail;
    logic locked;
    logic [7:0] ien;
    logic tx_flag;
    logic [1:0] rx_flag;
    logic [7:0] cfg;
    logic [7:0] ctl;
    logic [15:0] cap_line;
    logic [1:0] ev_sts;
    logic [1:0] ev_msk;
    logic [7:0] pre;
    logic [15:0] stamp_cnt;
    logic fs_q;
    logic fs_primed;
    logic [1:0] valid;
    logic ready;
    logic [15:0] ts0;
    logic [15:0] ts1;
    logic [15:0] line_cnt [2];

    wire sync_en = (i_sync_fwd_mode != 2'h0);
    wire gie = ien[`FWDIRQ_B_GIE];
    wire [2:0] src_en = {ien[`FWDIRQ_B_TX], ien[`FWDIRQ_B_RX1], ien[`FWDIRQ_B_RX0]};
    wire [2:0] src_flag = {tx_flag, rx_flag};
    wire summary = |(src_flag & src_en);
    wire ev_pending = |(ev_sts & ev_msk);
    wire next_irq = gie & (summary | ev_pending);

    //--------------------------------------------------
    // read mux
    //--------------------------------------------------
    wire [7:0] rd_fwd = {5'h00, sync_fail, 1'b0, locked};
    wire [7:0] rd_isrc = {summary, 2'h0, tx_flag, 2'h0, rx_flag};
    wire [7:0] rd_sts = {3'h0, ready, 2'h0, valid};
    wire [7:0] rd_evs = {6'h00, ev_sts};
    wire [7:0] next_rd8 =
        hit_fwd ? rd_fwd :
        hit_ien ? ien :
        hit_isrc ? rd_isrc :
        hit_cfg ? cfg :
        hit_ctl ? ctl :
        hit_lhi ? cap_line[15:8] :
        hit_llo ? cap_line[7:0] :
        hit_sts ? rd_sts :
        hit_t0h ? ts0[15:8] :
        hit_t0l ? ts0[7:0] :
        hit_t1h ? ts1[15:8] :
        hit_t1l ? ts1[7:0] :
        hit_evs ? rd_evs :
        hit_evm ? {6'h00, ev_msk} :
        `FWDIRQ_RST8;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~hit_any;
            prdata <= setup ? {24'h000000, next_rd8} : 32'h00000000;
        end
    end
    assign o_apb = '{pready: pready, pslverr: pslverr, prdata: prdata};

    //--------------------------------------------------
    // forwarding sync tracking
    //--------------------------------------------------
    // a loss counts only once a synced frame went out
    always_comb
    begin
        next_sync_state = sync_state;
        case (sync_state)
            fwdirq_pkg::FWDIRQ_IDLE:
                if (sync_en)
                    next_sync_state = fwdirq_pkg::FWDIRQ_WAIT_FRAME;
            fwdirq_pkg::FWDIRQ_WAIT_FRAME:
                if (!sync_en)
                    next_sync_state = fwdirq_pkg::FWDIRQ_IDLE;
                else if (i_frame_forwarded)
                    next_sync_state = fwdirq_pkg::FWDIRQ_PROVEN;
            fwdirq_pkg::FWDIRQ_PROVEN:
                if (!sync_en)
                    next_sync_state = fwdirq_pkg::FWDIRQ_IDLE;
                else if (i_sync_lost)
                    next_sync_state = fwdirq_pkg::FWDIRQ_WAIT_FRAME;
            default:
                next_sync_state = fwdirq_pkg::FWDIRQ_IDLE;
        endcase
    end

    // set only after a good frame
    wire fail_set = (sync_state == fwdirq_pkg::FWDIRQ_PROVEN) & sync_en & i_sync_lost;
    wire fail_clr = rd & hit_fwd & prdata[`FWDIRQ_B_FAIL];
    wire next_tx = i_tx_irq | (tx_flag & ~i_tx_event_read);
    wire [1:0] next_rx = i_rx_irq | (rx_flag & ~i_rx_event_read);
    wire [1:0] ev_set = {ready & ~o_stamp_ready, fail_set};
    wire [1:0] ev_clr = (rd & hit_evs) ? prdata[1:0] : 2'h0;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sync_state <= fwdirq_pkg::FWDIRQ_IDLE;
            sync_fail <= 1'b0;
            locked <= 1'b0;
            tx_flag <= 1'b0;
            rx_flag <= 2'h0;
            ev_sts <= 2'h0;
            o_irq <= 1'b0;
        end
        else
        begin
            sync_state <= next_sync_state;
            sync_fail <= fail_set | (sync_fail & ~fail_clr);
            // locked follows engine only in synced mode
            locked <= sync_en & i_engine_locked;
            tx_flag <= next_tx;
            rx_flag <= next_rx;
            ev_sts <= ev_set | (ev_sts & ~ev_clr);
            o_irq <= next_irq;
        end
    end

    //--------------------------------------------------
    // writable registers
    //--------------------------------------------------
    wire [7:0] next_ctl = (wr & hit_ctl) ? (wdat & `FWDIRQ_M_TSCTL) : ctl;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ien <= `FWDIRQ_RST8;
            cfg <= `FWDIRQ_RST8;
            ctl <= `FWDIRQ_RST8;
            cap_line <= `FWDIRQ_RST16;
            ev_msk <= 2'h0;
        end
        else
        begin
            if (wr & hit_ien)
                ien <= wdat & `FWDIRQ_M_IEN;
            if (wr & hit_cfg)
                cfg <= wdat & `FWDIRQ_M_TSCFG;
            ctl <= next_ctl;
            if (wr & hit_lhi)
                cap_line[15:8] <= wdat;
            if (wr & hit_llo)
                cap_line[7:0] <= wdat;
            if (wr & hit_evm)
                ev_msk <= 2'(wdat & `FWDIRQ_M_EVM);
        end
    end

    //--------------------------------------------------
    // stamp counter
    //--------------------------------------------------
    wire [1:0] res = cfg[`FWDIRQ_B_RESH:`FWDIRQ_B_RESL];
    wire free_run = cfg[`FWDIRQ_B_FREE];
    wire frame_mode = cfg[`FWDIRQ_B_MODE];
    wire freeze = ctl[`FWDIRQ_B_FRZ];
    wire [1:0] ts_en = ctl[1:0];
    wire [7:0] tick_cycles =
        (res == 2'h0) ? 8'((`FWDIRQ_TICK0_NS + `FWDIRQ_CLK_NS - 1) / `FWDIRQ_CLK_NS) :
        (res == 2'h1) ? 8'((`FWDIRQ_TICK1_NS + `FWDIRQ_CLK_NS - 1) / `FWDIRQ_CLK_NS) :
        (res == 2'h2) ? 8'((`FWDIRQ_TICK2_NS + `FWDIRQ_CLK_NS - 1) / `FWDIRQ_CLK_NS) :
        8'((`FWDIRQ_TICK3_NS + `FWDIRQ_CLK_NS - 1) / `FWDIRQ_CLK_NS);
    wire tick = (pre >= tick_cycles - 8'h01);
    // edge select
    // no edge in the first cycle after reset, whatever level the pin idles at
    wire fs_edge = fs_primed & (cfg[`FWDIRQ_B_POL] ? (fs_q & ~i_frame_sync) : (~fs_q & i_frame_sync));
    // frame-sync mode restarts the count on each active edge
    wire cnt_restart = ~free_run & fs_edge;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pre <= `FWDIRQ_RST8;
            stamp_cnt <= `FWDIRQ_RST16;
            fs_q <= 1'b0;
            fs_primed <= 1'b0;
        end
        else
        begin
            fs_q <= i_frame_sync;
            fs_primed <= 1'b1;
            pre <= (tick | cnt_restart) ? `FWDIRQ_RST8 : pre + 8'h01;
            if (cnt_restart)
                stamp_cnt <= `FWDIRQ_RST16;
            else if (tick)
                stamp_cnt <= stamp_cnt + 16'h0001;
        end
    end

    //--------------------------------------------------
    // per-port capture
    //--------------------------------------------------
    logic [1:0] cap;
    for (genvar p = 0; p < 2; p++)
    begin : g_port
        // line mode hits the programmed line number
        wire line_hit = i_line_start[p] & ((line_cnt[p] + 16'h0001) == cap_line);
        assign cap[p] = ts_en[p] & ~freeze & ~ready & (frame_mode ? i_frame_start[p] : line_hit);
        always_ff @(posedge i_clock or negedge i_rst_b)
        begin
            if (!i_rst_b)
                line_cnt[p] <= `FWDIRQ_RST16;
            else if (i_frame_start[p])
                line_cnt[p] <= `FWDIRQ_RST16;
            else if (i_line_start[p])
                line_cnt[p] <= line_cnt[p] + 16'h0001;
        end
    end

    wire all_valid = (&(valid | ~ts_en)) & (|ts_en);
    wire thaw = ctl[`FWDIRQ_B_FRZ] & ~next_ctl[`FWDIRQ_B_FRZ];
    // early ready, otherwise wait for the next active frame-sync edge
    wire ready_set = all_valid & ~freeze & (cfg[`FWDIRQ_B_EARLY] | fs_edge);

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ts0 <= `FWDIRQ_RST16;
            ts1 <= `FWDIRQ_RST16;
            valid <= 2'h0;
            ready <= 1'b0;
            o_stamp_ready <= 1'b0;
        end
        else
        begin
            if (cap[0])
                ts0 <= stamp_cnt;
            if (cap[1])
                ts1 <= stamp_cnt;
            valid <= thaw ? 2'h0 : (valid | cap);
            ready <= freeze ? 1'b0 : (ready | ready_set);
            o_stamp_ready <= ready;
        end
    end

    //--------------------------------------------------
    // checks
    //--------------------------------------------------
    logic [7:0] gap;
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            gap <= `FWDIRQ_RST8;
        else
            gap <= (tick | cnt_restart) ? `FWDIRQ_RST8 : gap + 8'h01;
    end

    property p_fail_after_frame;
        @(posedge i_clock) disable iff (!i_rst_b)
        $rose(sync_fail) |-> $past(sync_state) == fwdirq_pkg::FWDIRQ_PROVEN;
    endproperty
    a_fail_after_frame: assert property (p_fail_after_frame) else $error("loss flag before a good frame");

    property p_fail_rc;
        @(posedge i_clock) disable iff (!i_rst_b)
        (rd & hit_fwd & prdata[`FWDIRQ_B_FAIL] & ~fail_set) |=> !sync_fail;
    endproperty
    a_fail_rc: assert property (p_fail_rc) else $error("loss flag kept after read");

    property p_locked;
        @(posedge i_clock) disable iff (!i_rst_b)
        (sync_en && i_engine_locked) ##1 (sync_en && i_engine_locked) |-> locked;
    endproperty
    a_locked: assert property (p_locked) else $error("locked bit missing");

    property p_locked_off;
        @(posedge i_clock) disable iff (!i_rst_b)
        !sync_en |=> !rd_fwd[`FWDIRQ_B_LOCK];
    endproperty
    a_locked_off: assert property (p_locked_off) else $error("locked bit while sync off");

    property p_gie;
        @(posedge i_clock) disable iff (!i_rst_b)
        !gie |=> !o_irq;
    endproperty
    a_gie: assert property (p_gie) else $error("irq with global enable low");

    property p_summary;
        @(posedge i_clock) disable iff (!i_rst_b)
        (tx_flag && ien[`FWDIRQ_B_TX] && !gie) |-> rd_isrc[`FWDIRQ_B_SUM];
    endproperty
    a_summary: assert property (p_summary) else $error("summary ignores source");

    property p_irq_path;
        @(posedge i_clock) disable iff (!i_rst_b)
        (rx_flag[0] && ien[`FWDIRQ_B_RX0] && gie) |=> o_irq;
    endproperty
    a_irq_path: assert property (p_irq_path) else $error("irq not raised");

    property p_tx_set;
        @(posedge i_clock) disable iff (!i_rst_b)
        i_tx_irq |=> tx_flag;
    endproperty
    a_tx_set: assert property (p_tx_set) else $error("tx event lost");

    property p_rx_hold;
        @(posedge i_clock) disable iff (!i_rst_b)
        (rx_flag[1] && !i_rx_event_read[1]) |=> rx_flag[1];
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx flag dropped unread");

    property p_tick;
        @(posedge i_clock) disable iff (!i_rst_b)
        (tick && $stable(res) && !cnt_restart) |-> gap == tick_cycles - 8'h01;
    endproperty
    a_tick: assert property (p_tick) else $error("tick period wrong");

    property p_early;
        @(posedge i_clock) disable iff (!i_rst_b)
        (all_valid && cfg[`FWDIRQ_B_EARLY] && !freeze) |=> ready;
    endproperty
    a_early: assert property (p_early) else $error("early ready late");

    property p_freeze;
        @(posedge i_clock) disable iff (!i_rst_b)
        freeze |=> !ready && $stable(ts0) && $stable(ts1);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen stamps moved");

    c_fail: cover property (@(posedge i_clock) disable iff (!i_rst_b) $rose(sync_fail));
    c_irq: cover property (@(posedge i_clock) disable iff (!i_rst_b) $rose(o_irq));
    c_ready: cover property (@(posedge i_clock) disable iff (!i_rst_b) $rose(o_stamp_ready));
endmodule : fwdirq_regs

// ===== fwdirq_cfg.svh
`ifndef FWDIRQ_CFG_SVH
`define FWDIRQ_CFG_SVH
// register indices; byte address is four times the index
`define FWDIRQ_I_FWD 6'h22
`define FWDIRQ_I_IEN 6'h23
`define FWDIRQ_I_ISRC 6'h24
`define FWDIRQ_I_TSCFG 6'h25
`define FWDIRQ_I_TSCTL 6'h26
`define FWDIRQ_I_LHI 6'h27
`define FWDIRQ_I_LLO 6'h28
`define FWDIRQ_I_TSSTS 6'h29
`define FWDIRQ_I_T0HI 6'h2A
`define FWDIRQ_I_T0LO 6'h2B
`define FWDIRQ_I_T1HI 6'h2C
`define FWDIRQ_I_T1LO 6'h2D
`define FWDIRQ_I_EVS 6'h2E
`define FWDIRQ_I_EVM 6'h2F
`define FWDIRQ_RST8 8'h00
`define FWDIRQ_RST16 16'h0000
// writable bit masks
`define FWDIRQ_M_IEN 8'h93
`define FWDIRQ_M_TSCFG 8'h7B
`define FWDIRQ_M_TSCTL 8'h13
`define FWDIRQ_M_EVM 8'h03
// field positions
`define FWDIRQ_B_FAIL 2
`define FWDIRQ_B_LOCK 0
`define FWDIRQ_B_GIE 7
`define FWDIRQ_B_SUM 7
`define FWDIRQ_B_TX 4
`define FWDIRQ_B_RX1 1
`define FWDIRQ_B_RX0 0
`define FWDIRQ_B_POL 6
`define FWDIRQ_B_RESH 5
`define FWDIRQ_B_RESL 4
`define FWDIRQ_B_EARLY 3
`define FWDIRQ_B_FREE 1
`define FWDIRQ_B_MODE 0
`define FWDIRQ_B_FRZ 4
`define FWDIRQ_B_RDY 4
`define FWDIRQ_B_EV_LOSS 0
`define FWDIRQ_B_EV_RDY 1
// timing
`define FWDIRQ_CLK_NS 5
`define FWDIRQ_TICK0_NS 40
`define FWDIRQ_TICK1_NS 80
`define FWDIRQ_TICK2_NS 160
`define FWDIRQ_TICK3_NS 1000
`endif

// ===== fwdirq_pkg.sv
package fwdirq_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } fwdirq_apb_req_type;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fwdirq_apb_rsp_type;
    typedef enum logic [1:0] {
        FWDIRQ_IDLE = 2'b00,
        FWDIRQ_WAIT_FRAME = 2'b01,
        FWDIRQ_PROVEN = 2'b11
    } fwdirq_sync_type;
endpackage : fwdirq_pkg

// ===== fwdirq_tb.sv
`timescale 1ns/100ps
`include "fwdirq_cfg.svh"
module testbench;
    // ------------------------------------------------------------
    // stimulus and design
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] wdata;
        logic [7:0] exp;
        logic err;
    } fwdirq_row_type;
    localparam logic [9:0] P_FF = 10'h200, P_SL = 10'h100, P_TXI = 10'h080, P_TXR = 10'h040;
    localparam logic [9:0] P_RX1I = 10'h020, P_RX0I = 10'h010, P_RX1R = 10'h008, P_RX0R = 10'h004;
    localparam logic [9:0] P_FS0 = 10'h001;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    fwdirq_pkg::fwdirq_apb_req_type req = '0;
    fwdirq_pkg::fwdirq_apb_rsp_type o_apb;
    logic [1:0] sync_mode = 2'h0;
    logic engine_locked = 1'b0;
    logic frame_fwd = 1'b0, sync_lost = 1'b0, tx_irq = 1'b0, tx_read = 1'b0;
    logic [1:0] rx_irq = 2'h0, rx_read = 2'h0, frame_start = 2'h0;
    logic frame_sync = 1'b0;
    logic [1:0] line_start = 2'h0;
    logic o_irq, o_stamp_ready;
    int errors = 0;
    int total_checks = 0;
    fwdirq_row_type rows [7];
    logic [31:0] rd;
    logic err;

    fwdirq_regs uut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_apb(req), .o_apb(o_apb),
        .i_sync_fwd_mode(sync_mode), .i_engine_locked(engine_locked),
        .i_frame_forwarded(frame_fwd), .i_sync_lost(sync_lost),
        .i_tx_irq(tx_irq), .i_tx_event_read(tx_read), .i_rx_irq(rx_irq), .i_rx_event_read(rx_read),
        .i_frame_sync(frame_sync), .i_line_start(line_start), .i_frame_start(frame_start),
        .o_irq(o_irq), .o_stamp_ready(o_stamp_ready)
    );

    initial
    begin
        forever #2.5 i_clock = ~i_clock;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task close_out;
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: register read %h, expected %h", $time, got, exp);
        end
    endtask : chk_reg

    // bounded wait on a level output; sel 0 watches the interrupt, 1 the stamp ready
    task wait_pin(input logic sel, input logic exp);
        int n;
        n = 0;
        while ((sel ? o_stamp_ready : o_irq) !== exp && n < 20)
        begin
            @(posedge i_clock);
            n++;
        end
        total_checks++;
        if ((sel ? o_stamp_ready : o_irq) !== exp)
        begin
            errors++;
            $display("Error at %0t: output %0d not at level %b", $time, sel, exp);
        end
    endtask : wait_pin

    // the master holds the whole request until pready is seen high at an edge
    task apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        int n;
        @(posedge i_clock);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= {idx, 2'b00};
        req.pwdata <= {24'h000000, wd};
        @(posedge i_clock);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clock);
            n++;
        end
        while (o_apb.pready !== 1'b1 && n < 20);
        if (o_apb.pready !== 1'b1)
        begin
            errors++;
            $display("Error at %0t: no pready", $time);
            close_out();
        end
        rd = o_apb.prdata;
        err = o_apb.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk_reg(rd, {24'h000000, exp});
    endtask : rd_chk

    task pulse(input logic [9:0] p);
        @(posedge i_clock);
        {frame_fwd, sync_lost, tx_irq, tx_read, rx_irq, rx_read, frame_start} <= p;
        @(posedge i_clock);
        {frame_fwd, sync_lost, tx_irq, tx_read, rx_irq, rx_read, frame_start} <= 10'h000;
        repeat (2) @(posedge i_clock);
    endtask : pulse

    // hold and release clear ready and the valid flags; a falling frame-sync edge restarts the count,
    // then port 0 line 2 is stamped gap + 1 cycles after that edge
    task stamp_run(input logic [7:0] cfg_val, input int gap, input logic [7:0] exp);
        apb(1'b1, `FWDIRQ_I_TSCTL, 8'h11);
        apb(1'b1, `FWDIRQ_I_TSCTL, 8'h01);
        apb(1'b1, `FWDIRQ_I_TSCFG, cfg_val);
        @(posedge i_clock);
        frame_sync <= 1'b1;
        frame_start <= 2'h1;
        @(posedge i_clock);
        frame_sync <= 1'b0;
        frame_start <= 2'h0;
        @(posedge i_clock);
        line_start <= 2'h1;
        @(posedge i_clock);
        line_start <= 2'h0;
        repeat (gap - 1) @(posedge i_clock);
        line_start <= 2'h1;
        @(posedge i_clock);
        line_start <= 2'h0;
        wait_pin(1'b1, 1'b1);
        rd_chk(`FWDIRQ_I_T0HI, 8'h00);
        rd_chk(`FWDIRQ_I_T0LO, exp);
    endtask : stamp_run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rows[0] = '{`FWDIRQ_I_FWD, 8'hFF, 8'h00, 1'b0};
        rows[1] = '{`FWDIRQ_I_ISRC, 8'hFF, 8'h00, 1'b0};
        rows[2] = '{`FWDIRQ_I_IEN, 8'hFF, `FWDIRQ_M_IEN, 1'b0};
        rows[3] = '{`FWDIRQ_I_IEN, 8'h00, 8'h00, 1'b0};
        rows[4] = '{`FWDIRQ_I_TSCFG, 8'hFF, `FWDIRQ_M_TSCFG, 1'b0};
        rows[5] = '{`FWDIRQ_I_TSCFG, 8'h00, 8'h00, 1'b0};
        rows[6] = '{6'h3F, 8'h12, 8'h00, 1'b1};
        repeat (12) @(posedge i_clock);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 4; i++)
            rd_chk(`FWDIRQ_I_FWD + i[5:0], `FWDIRQ_RST8);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].idx, rows[i].wdata);
            chk_reg({31'h00000000, err}, {31'h00000000, rows[i].err});
            rd_chk(rows[i].idx, rows[i].exp);
        end
        sync_mode <= 2'h1;
        pulse(P_SL);
        rd_chk(`FWDIRQ_I_FWD, 8'h00);
        pulse(P_FF);
        pulse(P_SL);
        rd_chk(`FWDIRQ_I_FWD, 8'h04);
        rd_chk(`FWDIRQ_I_FWD, 8'h00);
        engine_locked <= 1'b1;
        rd_chk(`FWDIRQ_I_FWD, 8'h01);
        sync_mode <= 2'h0;
        rd_chk(`FWDIRQ_I_FWD, 8'h00);
        engine_locked <= 1'b0;
        apb(1'b1, `FWDIRQ_I_IEN, 8'h01);
        pulse(P_RX1I);
        rd_chk(`FWDIRQ_I_ISRC, 8'h02);
        pulse(P_RX0I);
        rd_chk(`FWDIRQ_I_ISRC, 8'h83);
        wait_pin(1'b0, 1'b0);
        apb(1'b1, `FWDIRQ_I_IEN, 8'h81);
        wait_pin(1'b0, 1'b1);
        pulse(P_RX0R);
        rd_chk(`FWDIRQ_I_ISRC, 8'h02);
        wait_pin(1'b0, 1'b0);
        pulse(P_RX1R);
        rd_chk(`FWDIRQ_I_ISRC, 8'h00);
        apb(1'b1, `FWDIRQ_I_IEN, 8'h90);
        pulse(P_TXI);
        rd_chk(`FWDIRQ_I_ISRC, 8'h90);
        rd_chk(`FWDIRQ_I_ISRC, 8'h90);
        wait_pin(1'b0, 1'b1);
        pulse(P_TXR);
        rd_chk(`FWDIRQ_I_ISRC, 8'h00);
        wait_pin(1'b0, 1'b0);
        // frame start capture on port 0 with early ready
        apb(1'b1, `FWDIRQ_I_TSCFG, 8'h09);
        apb(1'b1, `FWDIRQ_I_TSCTL, 8'h01);
        pulse(P_FS0);
        wait_pin(1'b1, 1'b1);
        rd_chk(`FWDIRQ_I_TSSTS, 8'h11);
        apb(1'b1, `FWDIRQ_I_TSCTL, 8'h11);
        wait_pin(1'b1, 1'b0);
        rd_chk(`FWDIRQ_I_TSSTS, 8'h01);
        // event status holds the earlier sync loss and ready rise until read
        rd_chk(`FWDIRQ_I_EVS, 8'h03);
        rd_chk(`FWDIRQ_I_EVS, 8'h00);
        apb(1'b1, `FWDIRQ_I_EVM, 8'h02);
        rd_chk(`FWDIRQ_I_EVM, 8'h02);
        apb(1'b1, `FWDIRQ_I_LHI, 8'h00);
        apb(1'b1, `FWDIRQ_I_LLO, 8'h02);
        stamp_run(8'h48, 31, 8'(31 / (`FWDIRQ_TICK0_NS / `FWDIRQ_CLK_NS)));
        stamp_run(8'h78, 200, 8'(200 / (`FWDIRQ_TICK3_NS / `FWDIRQ_CLK_NS)));
        wait_pin(1'b0, 1'b1);
        rd_chk(`FWDIRQ_I_EVS, 8'h02);
        wait_pin(1'b0, 1'b0);
        // reset in mid-run with an interrupt pending
        pulse(P_TXI);
        wait_pin(1'b0, 1'b1);
        @(posedge i_clock);
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_clock);
        wait_pin(1'b0, 1'b0);
        i_rst_b <= 1'b1;
        rd_chk(`FWDIRQ_I_IEN, `FWDIRQ_RST8);
        rd_chk(`FWDIRQ_I_ISRC, `FWDIRQ_RST8);
        close_out();
    end
endmodule : testbench
